/* File: design/asc_pkg.sv */
// constants, states and carriers for the converter sequence control
package asc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_RES1 = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_RES4 = 3'h4;
  localparam int DONE_BIT = 7;
  localparam int SCAN_BIT = 5;
  localparam int GROUP_BIT = 4;
  localparam int SEL_HI = 3;
  localparam int GRP_LO = 2;
  localparam int CTL_W = 6;
  localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
  localparam int SAMPLE_CYCLES = 12;
  localparam int SAR_STEPS = 8;
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [1:0] RSV_GROUP = 2'h2;
  localparam logic [3:0] CH_RSV_TOP = 4'hf;
  localparam logic [DATA_W-1:0] SAR_MSB = 8'h80;
  localparam logic [2:0] SAR_TOP = 3'h7;
  localparam logic [2:0] SAR_BOT = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_SAMPLE = 3'b011,
    ST_CONVERT = 3'b010,
    ST_SUSPEND = 3'b110
  } asc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asc_bus_s;

  typedef struct packed {
    logic sample;
    logic muxEnable;
    logic [3:0] channel;
    logic [DATA_W-1:0] dacCode;
  } asc_ana_s;
endpackage

/* File: design/asc_sar.sv */
// eight-step successive approximation engine
module asc_sar (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic compHigh,
  // results
  output logic [asc_pkg::DATA_W-1:0] dacCode,
  output logic [asc_pkg::DATA_W-1:0] result,
  output logic done
);
  logic [asc_pkg::DATA_W-1:0] trial_r;
  logic [asc_pkg::DATA_W-1:0] result_r;
  logic [2:0] idx_r;
  logic busy_r;
  logic done_r;
  logic [asc_pkg::DATA_W-1:0] keep;
  logic [asc_pkg::DATA_W-1:0] trialNxt;

  localparam logic [asc_pkg::DATA_W-1:0] SAR_ONE = 8'h01;

  // keep the trial bit when input is at or above the trial level
  assign keep = compHigh ? trial_r : (trial_r & ~(SAR_ONE << idx_r));
  assign trialNxt = (idx_r == asc_pkg::SAR_BOT) ? keep : (keep | (SAR_ONE << (idx_r - 3'h1)));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trial_r <= '0;
      result_r <= '0;
      idx_r <= asc_pkg::SAR_TOP;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        busy_r <= 1'b0;
      end else if (start) begin
        trial_r <= asc_pkg::SAR_MSB;
        idx_r <= asc_pkg::SAR_TOP;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        trial_r <= trialNxt;
        idx_r <= idx_r - 3'h1;
        if (idx_r == asc_pkg::SAR_BOT) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          result_r <= keep;
        end
      end
    end
  end

  assign dacCode = trial_r;
  assign result = result_r;
  assign done = done_r;

  property p_eightSteps;
    @(posedge clk) disable iff (!resetn)
    done |-> $past(start, 9);
  endproperty
  a_eightSteps: assert property (p_eightSteps) else $error("result not eight steps after start");
endmodule // asc_sar

/* File: design/asc_seq_ctrl.sv */
// converter sequence control: register port, scan sequencer, stop and wait handling

module asc_seq_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire asc_pkg::asc_bus_s bus,
  output logic [asc_pkg::DATA_W-1:0] rdData,
  // power modes
  input wire logic stopMode,
  input wire logic waitMode,
  // analog side
  input wire logic compHigh,
  output asc_pkg::asc_ana_s ana
);
  asc_pkg::asc_state_e st_r;
  asc_pkg::asc_state_e st_nxt;
  logic [asc_pkg::CTL_W-1:0] ctl_r;
  logic doneFlag_r;
  logic [1:0] slot_r;
  logic [3:0] sampCnt_r;
  logic [asc_pkg::DATA_W-1:0] res_r [4];
  logic [asc_pkg::DATA_W-1:0] rdData_r;
  logic sample_r;
  logic muxEn_r;
  logic [3:0] chan_r;

  logic ctlWr;
  logic lowPower;
  logic scanOn;
  logic groupOn;
  logic lastSlot;
  logic sampleDone;
  logic sarStart;
  logic sarAbort;
  logic sarDone;
  logic convDone;
  logic [asc_pkg::DATA_W-1:0] sarResult;
  logic [asc_pkg::DATA_W-1:0] sarDac;
  logic [asc_pkg::CTL_W-1:0] ctl_nxt;
  logic [1:0] slot_nxt;
  logic [3:0] chan_nxt;
  logic chanReserved;
  logic ctlHit;
  logic resHit;
  logic [1:0] resIdx;
  logic [asc_pkg::DATA_W-1:0] rd_nxt;

  // decode
  assign ctlWr = bus.wr && (bus.addr == asc_pkg::OFF_CTL);
  assign lowPower = stopMode || waitMode;
  assign scanOn = ctl_r[asc_pkg::SCAN_BIT];
  assign groupOn = ctl_r[asc_pkg::GROUP_BIT];
  assign lastSlot = (slot_r == asc_pkg::SLOT_LAST);
  assign sampleDone = (st_r == asc_pkg::ST_SAMPLE) && (sampCnt_r == asc_pkg::SAMPLE_LAST);
  assign sarStart = sampleDone && !lowPower && !ctlWr;
  // leaving convert for any reason drops the partial approximation
  assign sarAbort = ctlWr || ((st_r == asc_pkg::ST_CONVERT) && lowPower);
  assign convDone = (st_r == asc_pkg::ST_CONVERT) && sarDone && !lowPower && !ctlWr;

  // next settings and slot
  assign ctl_nxt = ctlWr ? bus.wdata[asc_pkg::CTL_W-1:0] : ctl_r;
  assign slot_nxt = ctlWr ? asc_pkg::SLOT_FIRST : (convDone ? slot_r + 2'h1 : slot_r);
  assign chan_nxt = ctl_nxt[asc_pkg::GROUP_BIT] ?
                    {ctl_nxt[asc_pkg::SEL_HI:asc_pkg::GRP_LO], slot_nxt} :
                    ctl_nxt[asc_pkg::SEL_HI:0];
  assign chanReserved = (chan_nxt[3:2] == asc_pkg::RSV_GROUP) ||
                        (chan_nxt == asc_pkg::CH_RSV_TOP);

  // register reads
  assign ctlHit = bus.addr == asc_pkg::OFF_CTL;
  assign resHit = (bus.addr >= asc_pkg::OFF_RES1) && (bus.addr <= asc_pkg::OFF_RES4);
  assign resIdx = 2'(bus.addr - asc_pkg::OFF_RES1);
  assign rd_nxt = !bus.rd ? asc_pkg::RD_IDLE :
                  ctlHit ? {doneFlag_r, 1'b0, ctl_r} :
                  resHit ? res_r[resIdx] : asc_pkg::RD_IDLE;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      asc_pkg::ST_IDLE: begin
        st_nxt = asc_pkg::ST_IDLE;
      end
      asc_pkg::ST_START: begin
        st_nxt = lowPower ? asc_pkg::ST_SUSPEND : asc_pkg::ST_SAMPLE;
      end
      asc_pkg::ST_SAMPLE: begin
        if (lowPower) begin
          st_nxt = asc_pkg::ST_SUSPEND;
        end else if (sampleDone) begin
          st_nxt = asc_pkg::ST_CONVERT;
        end
      end
      asc_pkg::ST_CONVERT: begin
        if (lowPower) begin
          st_nxt = asc_pkg::ST_SUSPEND;
        end else if (sarDone) begin
          st_nxt = (lastSlot && !scanOn) ? asc_pkg::ST_IDLE : asc_pkg::ST_SAMPLE;
        end
      end
      asc_pkg::ST_SUSPEND: begin
        if (!lowPower) begin
          st_nxt = asc_pkg::ST_SAMPLE;
        end
      end
      default: begin
        st_nxt = asc_pkg::ST_IDLE;
      end
    endcase
    if (ctlWr) begin
      st_nxt = asc_pkg::ST_START;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= asc_pkg::ST_IDLE;
      ctl_r <= asc_pkg::CTL_RESET;
      slot_r <= asc_pkg::SLOT_FIRST;
    end else begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      slot_r <= slot_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      doneFlag_r <= 1'b0;
    end else if (ctlWr) begin
      doneFlag_r <= 1'b0;
    end else if (convDone && lastSlot) begin
      doneFlag_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sampCnt_r <= asc_pkg::CNT_ZERO;
    end else if (st_r == asc_pkg::ST_SAMPLE && !sampleDone) begin
      sampCnt_r <= sampCnt_r + 4'h1;
    end else begin
      sampCnt_r <= asc_pkg::CNT_ZERO;
    end
  end

  // results change only on a finished conversion, never on a bus write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        res_r[i] <= '0;
      end
    end else if (convDone) begin
      res_r[slot_r] <= sarResult;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= asc_pkg::RD_IDLE;
      sample_r <= 1'b0;
      muxEn_r <= 1'b0;
      chan_r <= '0;
    end else begin
      rdData_r <= rd_nxt;
      sample_r <= st_nxt == asc_pkg::ST_SAMPLE;
      muxEn_r <= (st_nxt == asc_pkg::ST_SAMPLE || st_nxt == asc_pkg::ST_CONVERT) &&
                 !chanReserved;
      chan_r <= chan_nxt;
    end
  end

  asc_sar u_sar (
    .clk(clk),
    .resetn(resetn),
    .start(sarStart),
    .abort(sarAbort),
    .compHigh(compHigh),
    .dacCode(sarDac),
    .result(sarResult),
    .done(sarDone)
  );

  assign rdData = rdData_r;
  assign ana.sample = sample_r;
  assign ana.muxEnable = muxEn_r;
  assign ana.channel = chan_r;
  assign ana.dacCode = sarDac;

  // checks
  sequence s_ctlWrite;
    ctlWr;
  endsequence

  sequence s_passEnd;
    convDone && lastSlot && !ctlWr;
  endsequence

  property p_wrClearsDone;
    @(posedge clk) disable iff (!resetn)
    s_ctlWrite |=> !doneFlag_r && (slot_r == asc_pkg::SLOT_FIRST);
  endproperty
  a_wrClearsDone: assert property (p_wrClearsDone) else $error("write left done flag set");

  property p_startAfterWrite;
    @(posedge clk) disable iff (!resetn)
    s_ctlWrite ##1 (!ctlWr && !lowPower) |-> st_r == asc_pkg::ST_START ##1 sample_r;
  endproperty
  a_startAfterWrite: assert property (p_startAfterWrite) else $error("sampling not one cycle after write");

  property p_writeAbandons;
    @(posedge clk) disable iff (!resetn)
    (st_r == asc_pkg::ST_CONVERT) && ctlWr |=> st_r == asc_pkg::ST_START;
  endproperty
  a_writeAbandons: assert property (p_writeAbandons) else $error("running sequence not abandoned");

  property p_bit6Zero;
    @(posedge clk) disable iff (!resetn)
    bus.rd && ctlHit |=> !rdData[6] && rdData[asc_pkg::DONE_BIT] == $past(doneFlag_r);
  endproperty
  a_bit6Zero: assert property (p_bit6Zero) else $error("control read shows wrong status bits");

  property p_doneAtPassEnd;
    @(posedge clk) disable iff (!resetn)
    $rose(doneFlag_r) |-> $past(convDone && lastSlot);
  endproperty
  a_doneAtPassEnd: assert property (p_doneAtPassEnd) else $error("done flag set before fourth result");

  property p_doneSet;
    @(posedge clk) disable iff (!resetn)
    s_passEnd |=> doneFlag_r;
  endproperty
  a_doneSet: assert property (p_doneSet) else $error("done flag missing after pass");

  property p_oneShotHalts;
    @(posedge clk) disable iff (!resetn)
    s_passEnd ##0 !scanOn ##1 !ctlWr |-> st_r == asc_pkg::ST_IDLE ##1 st_r == asc_pkg::ST_IDLE;
  endproperty
  a_oneShotHalts: assert property (p_oneShotHalts) else $error("one-shot pass did not halt");

  property p_scanWraps;
    @(posedge clk) disable iff (!resetn)
    s_passEnd ##0 scanOn |=> slot_r == asc_pkg::SLOT_FIRST && st_r == asc_pkg::ST_SAMPLE;
  endproperty
  a_scanWraps: assert property (p_scanWraps) else $error("scan did not wrap to first result");

  property p_suspendResample;
    @(posedge clk) disable iff (!resetn)
    (st_r == asc_pkg::ST_SUSPEND) && !lowPower && !ctlWr |=>
      sample_r && $stable(slot_r);
  endproperty
  a_suspendResample: assert property (p_suspendResample) else $error("no resample of same channel");

  property p_groupChannel;
    @(posedge clk) disable iff (!resetn)
    sample_r && groupOn |-> chan_r[1:0] == slot_r;
  endproperty
  a_groupChannel: assert property (p_groupChannel) else $error("group channel does not follow slot");

  property p_singleChannel;
    @(posedge clk) disable iff (!resetn)
    sample_r && !groupOn |-> chan_r == ctl_r[asc_pkg::SEL_HI:0];
  endproperty
  a_singleChannel: assert property (p_singleChannel) else $error("single channel not as selected");

  property p_resultsHold;
    @(posedge clk) disable iff (!resetn)
    !convDone |=> res_r[0] == $past(res_r[0]) && res_r[3] == $past(res_r[3]);
  endproperty
  a_resultsHold: assert property (p_resultsHold) else $error("result changed without conversion");

  property p_reservedOff;
    @(posedge clk) disable iff (!resetn)
    sample_r && (chan_r[3:2] == asc_pkg::RSV_GROUP) |-> !ana.muxEnable;
  endproperty
  a_reservedOff: assert property (p_reservedOff) else $error("reserved channel enabled");

  sequence s_convRun;
    (st_r == asc_pkg::ST_SAMPLE) ##1 (st_r == asc_pkg::ST_CONVERT);
  endsequence

  property p_convStartsMsb;
    @(posedge clk) disable iff (!resetn)
    sampleDone && !lowPower && !ctlWr |=>
      st_r == asc_pkg::ST_CONVERT && ana.dacCode == asc_pkg::SAR_MSB;
  endproperty
  a_convStartsMsb: assert property (p_convStartsMsb)
    else $error("conversion did not open at top bit");

  property p_storeAfterEight;
    @(posedge clk) disable iff (!resetn)
    s_convRun ##0 (!lowPower && !ctlWr) [*8] ##1 (!lowPower && !ctlWr) |-> convDone;
  endproperty
  a_storeAfterEight: assert property (p_storeAfterEight)
    else $error("result not stored after eight compares");

  property p_firstResult;
    @(posedge clk) disable iff (!resetn)
    convDone && (slot_r == asc_pkg::SLOT_FIRST) |=> res_r[0] == $past(sarResult);
  endproperty
  a_firstResult: assert property (p_firstResult)
    else $error("first slot result not in result one");

  property p_resultRead;
    @(posedge clk) disable iff (!resetn)
    bus.rd && (bus.addr == asc_pkg::OFF_RES1) |=> rdData == $past(res_r[0]);
  endproperty
  a_resultRead: assert property (p_resultRead)
    else $error("result one read back wrong");

  property p_scanKeepsDone;
    @(posedge clk) disable iff (!resetn)
    doneFlag_r && scanOn && !ctlWr |=> doneFlag_r;
  endproperty
  a_scanKeepsDone: assert property (p_scanKeepsDone)
    else $error("done flag dropped during scan");

  property p_idleQuiet;
    @(posedge clk) disable iff (!resetn)
    st_r == asc_pkg::ST_IDLE |-> !sample_r && !muxEn_r;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet)
    else $error("analog side active while idle");

  property p_lowPowerSuspends;
    @(posedge clk) disable iff (!resetn)
    (st_r == asc_pkg::ST_SAMPLE || st_r == asc_pkg::ST_CONVERT) && lowPower && !ctlWr |=>
      st_r == asc_pkg::ST_SUSPEND && !sample_r;
  endproperty
  a_lowPowerSuspends: assert property (p_lowPowerSuspends)
    else $error("low power did not suspend");

  property p_suspendHolds;
    @(posedge clk) disable iff (!resetn)
    (st_r == asc_pkg::ST_SUSPEND) && lowPower && !ctlWr |=>
      st_r == asc_pkg::ST_SUSPEND && $stable(slot_r);
  endproperty
  a_suspendHolds: assert property (p_suspendHolds)
    else $error("suspend left or slot moved");
endmodule // asc_seq_ctrl

/* File: verif/asc_ana_model.sv */
// behavioural analog multiplexer and comparator facing the sequence control
module asc_ana_model (
  // analog side
  input wire asc_pkg::asc_ana_s ana,
  // test offset added to the external inputs
  input wire logic [7:0] bias,
  // comparator
  output logic compHigh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] level;
  logic flip = 1'b0;
  // inputs read as {channel, a} plus offset; references at rails and mid scale
  assign level = (ana.channel == 4'hc) ? 8'hff :
    (ana.channel == 4'hd) ? 8'h00 :
    (ana.channel == 4'he) ? 8'h80 :
    {ana.channel, 4'ha} + bias;
  // switch open: floating node, answer keeps changing
  always @(ana.dacCode) flip = ~flip;
  assign compHigh = ana.muxEnable ? (level >= ana.dacCode) : flip;
endmodule // asc_ana_model

/* File: verif/adc_sequence_control_test.sv */
// self-checking bench for the converter sequence control
module adc_sequence_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  asc_pkg::asc_bus_s bus = '0;
  logic [7:0] rdData;
  logic stopMode = 1'b0;
  logic waitMode = 1'b0;
  logic compHigh;
  asc_pkg::asc_ana_s ana;
  logic [7:0] bias = 8'h00;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int muxCnt = 0;

  always #50 clk = ~clk;

  asc_seq_ctrl u_asc_seq_ctrl (.clk(clk), .resetn(resetn), .bus(bus), .rdData(rdData),
    .stopMode(stopMode), .waitMode(waitMode), .compHigh(compHigh), .ana(ana));
  asc_ana_model u_asc_ana_model (.ana(ana), .bias(bias), .compHigh(compHigh));

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, run needs about a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (ana.muxEnable === 1'b1) muxCnt++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_raw(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_raw(a, d);
    chk(d, exp);
  endtask

  // control write, sample window opens on the next edge
  task automatic start(input logic [7:0] d, input logic [3:0] ch);
    wr(3'h0, d);
    #1 chk({7'h0, ana.sample}, 8'h00);
    chk({4'h0, ana.channel}, {4'h0, ch});
    @(posedge clk);
    #1 chk({7'h0, ana.sample}, 8'h01);
  endtask

  task automatic wait_done();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 200 && d[7] !== 1'b1; i++) rd_raw(3'h0, d);
    chk({7'h0, d[7]}, 8'h01);
  endtask

  // e[31:24] is result one
  task automatic chk_res(input logic [31:0] e);
    for (int i = 0; i < 4; i++) rd(3'(i + 1), e[31 - 8 * i -: 8]);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(3'h0, 8'h00);
    chk_res(32'h0);
    rd(3'h5, 8'h00);
    $display("test reset done");
    start(8'h03, 4'h3);
    rd(3'h0, 8'h03);
    wait_done();
    chk_res(32'h3a3a3a3a);
    rd(3'h0, 8'h83);
    wr(3'h0, 8'hc3);
    rd(3'h0, 8'h03);
    wr(3'h1, 8'h55);
    rd(3'h1, 8'h3a);
    $display("test single done");
    start(8'h14, 4'h4);
    wait_done();
    chk_res(32'h4a5a6a7a);
    start(8'h1c, 4'hc);
    wait_done();
    rd(3'h1, 8'hff);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h80);
    muxCnt = 0;
    start(8'h08, 4'h8);
    wait_done();
    chk({7'h0, muxCnt != 0}, 8'h00);
    $display("test group done");
    start(8'h15, 4'h4);
    repeat (30) @(posedge clk);
    start(8'h02, 4'h2);
    rd(3'h0, 8'h02);
    wait_done();
    chk_res(32'h2a2a2a2a);
    $display("test abort done");
    for (int m = 0; m < 2; m++) begin
      start(8'h07, 4'h7);
      repeat (30) @(posedge clk);
      stopMode <= (m == 0);
      waitMode <= (m == 1);
      repeat (40) @(posedge clk);
      #1 chk({7'h0, ana.sample}, 8'h00);
      rd(3'h0, 8'h07);
      @(posedge clk);
      stopMode <= 1'b0;
      waitMode <= 1'b0;
      wait_done();
      chk_res(32'h7a7a7a7a);
    end
    $display("test suspend done");
    start(8'h30, 4'h0);
    wait_done();
    chk_res(32'h0a1a2a3a);
    bias <= 8'h01;
    repeat (110) @(posedge clk);
    chk_res(32'h0b1b2b3b);
    rd(3'h0, 8'hb0);
    $display("test scan done");
    test_done();
  end
endmodule // adc_sequence_control_test
